// ---- rtl/can_ext_filter_txbuf.sv ----
// extended id acceptance filter walk and tx buffer section configuration
`timescale 1ns/1ps
`include "can_filter_consts.svh"
// Functional notes
// - second id bits 10:9 pick buffer or debug
// - second id bits 5:0 give rx buffer index
// - up to 64 extended filter elements
// - element address is list start plus twice index
// - two words: config, first id; type, second id
// - walk in order, stop at first match
// - priority codes set flag, irq, status
// - codes: off, fifo0, fifo1, reject, priority variants
// - code 7 routes to buffer, type ignored
// - buffer routing needs exact masked id match
// - type 0 is range first to second id
// - read-only bcd version register
// - status follows writes after a delay
// - tx config writable only with cce and init
// - dedicated tx buffers precede shared ones
// - bit 30 selects fifo or queue
// - shared count above 32 is used as 32 in the layout, the register reads back raw
// - dedicated count above 32 is used as 32 in the layout, the register reads back raw
module can_ext_filter_txbuf
  import can_filter_pkg::*;
#(
  parameter int ELEM_WORDS = 4,
  parameter logic [3:0] REL_DIGIT = 4'h1, // arbitrary value
  parameter logic [3:0] STEP_DIGIT = 4'h0, // arbitrary value
  parameter logic [3:0] MINOR_DIGIT = 4'h0, // arbitrary value
  parameter logic [3:0] YEAR_DIGIT = 4'h0, // arbitrary value
  parameter logic [7:0] MONTH_BCD = 8'h01, // arbitrary value
  parameter logic [7:0] DAY_BCD = 8'h01 // arbitrary value
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  // frame to filter
  input wire logic filt_start,
  input wire logic [28:0] rx_ext_id,
  // message ram read port, data sampled at the edge that ends the strobe cycle
  output logic ram_rd_ff,
  output logic [13:0] ram_addr_ff,
  input wire logic [31:0] ram_rdata,
  // filter outcome
  output logic filt_busy_ff,
  output logic filt_done_ff,
  output filt_result_t filt_result_ff,
  // interrupt and tx layout
  output logic hpm_irq_ff,
  output tx_layout_t tx_layout_ff
);

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  localparam logic [31:0] CORE_VERSION = {REL_DIGIT, STEP_DIGIT, MINOR_DIGIT,
                                          YEAR_DIGIT, MONTH_BCD, DAY_BCD};

  logic [1:0] ctrl_ff, nxt_ctrl;
  logic hpm_flag_ff, nxt_hpm_flag;
  logic hpm_en_ff, nxt_hpm_en;
  logic [13:0] list_start_ff, nxt_list_start;
  logic [6:0] list_size_ff, nxt_list_size;
  logic [28:0] xid_mask_ff, nxt_xid_mask;
  logic [9:0] prio_status_ff, nxt_prio_status;
  logic [31:0] txbc_ff, nxt_txbc;
  logic [31:0] nxt_rdata;
  logic nxt_irq;
  tx_layout_t nxt_layout;
  logic cfg_unlocked;
  logic hpm_event;
  logic [5:0] shared_eff;
  logic [5:0] ded_eff;
  logic [15:0] ded_span;

  assign cfg_unlocked = ctrl_ff[`CTRL_CCE_BIT] && ctrl_ff[`CTRL_INIT_BIT];

  // writes, reads and the sticky priority flag
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_hpm_en = hpm_en_ff;
    nxt_list_start = list_start_ff;
    nxt_list_size = list_size_ff;
    nxt_xid_mask = xid_mask_ff;
    nxt_txbc = txbc_ff;
    nxt_hpm_flag = hpm_flag_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr)
    begin
      if (reg_addr == `OFS_CONTROL)
        nxt_ctrl = reg_wdata[1:0];
      else if (reg_addr == `OFS_INT_FLAG && reg_wdata[`INT_HPM_BIT])
        nxt_hpm_flag = 1'b0; // write one to clear
      else if (reg_addr == `OFS_INT_ENABLE)
        nxt_hpm_en = reg_wdata[`INT_HPM_BIT];
      else if (reg_addr == `OFS_EXT_FILTER_CFG)
      begin
        nxt_list_start = reg_wdata[`ADDR_HI:`ADDR_LO];
        // larger sizes than the element limit are cut back
        nxt_list_size = (reg_wdata[`EFC_SIZE_HI:`EFC_SIZE_LO] > `EXT_FILTER_MAX) ?
                        `EXT_FILTER_MAX : reg_wdata[`EFC_SIZE_HI:`EFC_SIZE_LO];
      end
      else if (reg_addr == `OFS_EXT_ID_MASK)
        nxt_xid_mask = reg_wdata[`EFE_ID_HI:0];
      else if (reg_addr == `OFS_TX_BUFFER_CONFIG && cfg_unlocked)
        nxt_txbc = {1'b0, reg_wdata[`TXBC_MODE_BIT], reg_wdata[29:24], 2'b00,
                    reg_wdata[21:16], reg_wdata[`ADDR_HI:`ADDR_LO], 2'b00};
    end
    // a match in the clearing cycle wins over the clear
    if (hpm_event)
      nxt_hpm_flag = 1'b1;
    if (reg_rd)
    begin
      if (reg_addr == `OFS_CORE_VERSION)
        nxt_rdata = CORE_VERSION;
      else if (reg_addr == `OFS_CONTROL)
        nxt_rdata = {30'h0, ctrl_ff};
      else if (reg_addr == `OFS_INT_FLAG)
        nxt_rdata = {23'h0, hpm_flag_ff, 8'h00};
      else if (reg_addr == `OFS_INT_ENABLE)
        nxt_rdata = {23'h0, hpm_en_ff, 8'h00};
      else if (reg_addr == `OFS_EXT_FILTER_CFG)
        nxt_rdata = {9'h0, list_size_ff, list_start_ff, 2'b00};
      else if (reg_addr == `OFS_EXT_ID_MASK)
        nxt_rdata = {3'h0, xid_mask_ff};
      else if (reg_addr == `OFS_PRIO_STATUS)
        nxt_rdata = {22'h0, prio_status_ff};
      else if (reg_addr == `OFS_TX_BUFFER_CONFIG)
        nxt_rdata = txbc_ff;
    end
  end

  // effective tx layout, one cycle behind the register
  always_comb
  begin
    shared_eff = (txbc_ff[`TXBC_SHARED_HI:`TXBC_SHARED_LO] > `TX_COUNT_MAX) ?
                 `TX_COUNT_MAX : txbc_ff[`TXBC_SHARED_HI:`TXBC_SHARED_LO];
    ded_eff = (txbc_ff[`TXBC_DED_HI:`TXBC_DED_LO] > `TX_COUNT_MAX) ?
              `TX_COUNT_MAX : txbc_ff[`TXBC_DED_HI:`TXBC_DED_LO];
    ded_span = 16'(ded_eff * ELEM_WORDS);
    nxt_layout.queue_mode = txbc_ff[`TXBC_MODE_BIT];
    nxt_layout.shared_cnt = shared_eff;
    nxt_layout.dedicated_cnt = ded_eff;
    nxt_layout.dedicated_start = txbc_ff[`ADDR_HI:`ADDR_LO];
    // no check on the sum, overlap is the programmer's problem
    nxt_layout.shared_start = txbc_ff[`ADDR_HI:`ADDR_LO] + ded_span[13:0];
    nxt_irq = hpm_flag_ff && hpm_en_ff;
  end

  // register state; status views lag a write by a cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_ff <= `CTRL_RESET;
      hpm_flag_ff <= 1'b0;
      hpm_en_ff <= 1'b0;
      list_start_ff <= 14'h0000;
      list_size_ff <= 7'h00;
      xid_mask_ff <= `XID_MASK_RESET;
      txbc_ff <= `TXBC_RESET;
      reg_rdata_ff <= 32'h0000_0000;
      tx_layout_ff <= '0;
      hpm_irq_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      hpm_flag_ff <= nxt_hpm_flag;
      hpm_en_ff <= nxt_hpm_en;
      list_start_ff <= nxt_list_start;
      list_size_ff <= nxt_list_size;
      xid_mask_ff <= nxt_xid_mask;
      txbc_ff <= nxt_txbc;
      reg_rdata_ff <= nxt_rdata;
      tx_layout_ff <= nxt_layout;
      hpm_irq_ff <= nxt_irq;
    end
  end

  // -----------------------------------------------------------------
  // filter walk
  // -----------------------------------------------------------------
  filt_state_t state_ff, nxt_state;
  logic [5:0] idx_ff, nxt_idx;
  logic [28:0] id_ff, nxt_id;
  logic [31:0] f0_ff, nxt_f0;
  logic nxt_ram_rd;
  logic [13:0] nxt_ram_addr;
  logic nxt_busy;
  logic nxt_done;
  filt_result_t nxt_result;
  logic [2:0] efe_cfg;
  logic [1:0] efe_type;
  logic [28:0] id1;
  logic [28:0] id2;
  logic hit;
  logic last;

  assign efe_cfg = f0_ff[`EFE_CFG_HI:`EFE_CFG_LO];
  assign efe_type = ram_rdata[`EFE_TYPE_HI:`EFE_TYPE_LO];
  assign id1 = f0_ff[`EFE_ID_HI:0];
  assign id2 = ram_rdata[`EFE_ID_HI:0];
  assign last = ({1'b0, idx_ff} == list_size_ff - 7'h01);
  assign hpm_event = (state_ff == S_F1) && hit && efe_cfg[2] && (efe_cfg != 3'h7);

  // element match: code 7 ignores the type and wants an exact masked id
  always_comb
  begin
    hit = 1'b0;
    if (efe_cfg == 3'h7)
      hit = (id_ff == id1);
    else if (efe_cfg != 3'h0)
    begin
      case (efe_type)
        2'h0: hit = (id_ff >= id1) && (id_ff <= id2);
        2'h1: hit = (id_ff == id1) || (id_ff == id2);
        2'h2: hit = ((id_ff & id2) == (id1 & id2));
        default: hit = (id_ff >= id1) && (id_ff <= id2);
      endcase
    end
  end

  // walk state machine
  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_id = id_ff;
    nxt_f0 = f0_ff;
    nxt_ram_rd = 1'b0;
    nxt_ram_addr = ram_addr_ff;
    nxt_busy = filt_busy_ff;
    nxt_done = 1'b0;
    nxt_result = filt_result_ff;
    nxt_prio_status = prio_status_ff;
    case (state_ff)
      S_IDLE:
      begin
        if (filt_start)
        begin
          nxt_result = '0;
          nxt_id = rx_ext_id & xid_mask_ff;
          nxt_idx = 6'h00;
          if (list_size_ff == 7'h00)
            nxt_done = 1'b1;
          else
          begin
            nxt_ram_rd = 1'b1;
            nxt_ram_addr = list_start_ff;
            nxt_busy = 1'b1;
            nxt_state = S_F0;
          end
        end
      end
      S_F0:
      begin
        nxt_f0 = ram_rdata;
        nxt_ram_rd = 1'b1;
        nxt_ram_addr = ram_addr_ff + 14'h0001;
        nxt_state = S_F1;
      end
      S_F1:
      begin
        if (hit)
        begin
          nxt_result.matched = 1'b1;
          nxt_result.index = idx_ff;
          case (efe_cfg)
            3'h1: nxt_result.dest = DEST_FIFO0;
            3'h2: nxt_result.dest = DEST_FIFO1;
            3'h5: nxt_result.dest = DEST_FIFO0;
            3'h6: nxt_result.dest = DEST_FIFO1;
            3'h7: nxt_result.dest = DEST_RXBUF;
            default: nxt_result.dest = DEST_NONE;
          endcase
          nxt_result.accept = (efe_cfg != 3'h3) && (efe_cfg != 3'h4);
          nxt_result.rxbuf_idx = id2[`ROUTE_IDX_HI:0];
          nxt_result.debug_kind = id2[`ROUTE_KIND_HI:`ROUTE_KIND_LO];
          nxt_result.prio = hpm_event;
          if (hpm_event)
            nxt_prio_status = {1'b1, 1'b0, idx_ff, efe_cfg[1:0]};
        end
        if (hit || last)
        begin
          nxt_done = 1'b1;
          nxt_busy = 1'b0;
          nxt_state = S_IDLE;
        end
        else
        begin
          nxt_idx = idx_ff + 6'h01;
          nxt_ram_rd = 1'b1;
          nxt_ram_addr = list_start_ff + {7'h00, idx_ff + 6'h01, 1'b0};
          nxt_state = S_F0;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // walk registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff <= S_IDLE;
      idx_ff <= 6'h00;
      id_ff <= 29'h0000_0000;
      f0_ff <= 32'h0000_0000;
      ram_rd_ff <= 1'b0;
      ram_addr_ff <= 14'h0000;
      filt_busy_ff <= 1'b0;
      filt_done_ff <= 1'b0;
      filt_result_ff <= '0;
      prio_status_ff <= 10'h000;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      id_ff <= nxt_id;
      f0_ff <= nxt_f0;
      ram_rd_ff <= nxt_ram_rd;
      ram_addr_ff <= nxt_ram_addr;
      filt_busy_ff <= nxt_busy;
      filt_done_ff <= nxt_done;
      filt_result_ff <= nxt_result;
      prio_status_ff <= nxt_prio_status;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  sequence s_first_word;
    state_ff == S_F0 && ram_addr_ff == list_start_ff + {7'h00, idx_ff, 1'b0};
  endsequence
  sequence s_second_word;
    state_ff == S_F1 && ram_addr_ff == list_start_ff + {7'h00, idx_ff, 1'b1};
  endsequence

  property p_elem_addr;
    @(posedge clk) disable iff (srst) state_ff == S_F0 |-> s_first_word ##1 s_second_word;
  endproperty
  a_elem_addr: assert property (p_elem_addr) else $error("bad element address");

  property p_done_once;
    @(posedge clk) disable iff (srst) filt_done_ff && !filt_start |=> !filt_done_ff;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done held too long");

  property p_stop_at_hit;
    @(posedge clk) disable iff (srst) (state_ff == S_F1 && hit) |=> filt_done_ff && state_ff == S_IDLE;
  endproperty
  a_stop_at_hit: assert property (p_stop_at_hit) else $error("walk went past match");

  property p_hpm_set;
    @(posedge clk) disable iff (srst)
      filt_done_ff && filt_result_ff.prio |-> hpm_flag_ff && prio_status_ff[7:2] == filt_result_ff.index;
  endproperty
  a_hpm_set: assert property (p_hpm_set) else $error("priority flag not set");

  property p_irq;
    @(posedge clk) disable iff (srst) (hpm_flag_ff && hpm_en_ff) |=> hpm_irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_txbc_locked;
    @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == `OFS_TX_BUFFER_CONFIG && !cfg_unlocked) |=> $stable(txbc_ff);
  endproperty
  a_txbc_locked: assert property (p_txbc_locked) else $error("locked write took");

  property p_counts_clamped;
    @(posedge clk) disable iff (srst)
      tx_layout_ff.shared_cnt <= 6'h20 && tx_layout_ff.dedicated_cnt <= 6'h20;
  endproperty
  a_counts_clamped: assert property (p_counts_clamped) else $error("count above 32");

  property p_version_read;
    @(posedge clk) disable iff (srst)
      reg_rd && reg_addr == `OFS_CORE_VERSION |=> reg_rdata_ff == CORE_VERSION;
  endproperty
  a_version_read: assert property (p_version_read) else $error("version read wrong");

  property p_rxbuf_accept;
    @(posedge clk) disable iff (srst)
      filt_done_ff && filt_result_ff.dest == DEST_RXBUF |-> filt_result_ff.accept;
  endproperty
  a_rxbuf_accept: assert property (p_rxbuf_accept) else $error("rx buffer not accepted");

endmodule : can_ext_filter_txbuf

// ---- rtl/can_filter_consts.svh ----
// register offsets, field positions, reset values and limits
`ifndef CAN_FILTER_CONSTS_SVH
`define CAN_FILTER_CONSTS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define OFS_CORE_VERSION 8'h00
`define OFS_CONTROL 8'h18
`define OFS_INT_FLAG 8'h50
`define OFS_INT_ENABLE 8'h54
`define OFS_EXT_FILTER_CFG 8'h84
`define OFS_EXT_ID_MASK 8'h88
`define OFS_PRIO_STATUS 8'h8c
`define OFS_TX_BUFFER_CONFIG 8'hc0

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CTRL_INIT_BIT 0
`define CTRL_CCE_BIT 1
`define INT_HPM_BIT 8
`define TXBC_MODE_BIT 30
`define TXBC_SHARED_HI 29
`define TXBC_SHARED_LO 24
`define TXBC_DED_HI 21
`define TXBC_DED_LO 16
`define ADDR_HI 15
`define ADDR_LO 2
`define EFC_SIZE_HI 22
`define EFC_SIZE_LO 16
`define EFE_CFG_HI 31
`define EFE_CFG_LO 29
`define EFE_TYPE_HI 31
`define EFE_TYPE_LO 30
`define EFE_ID_HI 28
`define ROUTE_KIND_HI 10
`define ROUTE_KIND_LO 9
`define ROUTE_IDX_HI 5

// -----------------------------------------------------------------
// reset values and limits
// -----------------------------------------------------------------
`define TXBC_RESET 32'h0000_0000
`define CTRL_RESET 2'h1
`define XID_MASK_RESET 29'h1fff_ffff
`define TX_COUNT_MAX 6'h20
`define EXT_FILTER_MAX 7'h40

`endif

// ---- rtl/can_filter_pkg.sv ----
// types shared by the extended filter and tx buffer configuration block
package can_filter_pkg;

  // filter walk states
  typedef enum logic [1:0] {S_IDLE, S_F0, S_F1} filt_state_t;

  // where an accepted frame goes
  typedef enum logic [1:0] {DEST_NONE, DEST_FIFO0, DEST_FIFO1, DEST_RXBUF} dest_t;

  // outcome of one filter walk
  typedef struct packed {
    logic accept;
    dest_t dest;
    logic matched;
    logic [5:0] index;
    logic [5:0] rxbuf_idx;
    logic [1:0] debug_kind;
    logic prio;
  } filt_result_t;

  // effective tx buffer layout in message ram (word addresses)
  typedef struct packed {
    logic queue_mode;
    logic [5:0] shared_cnt;
    logic [5:0] dedicated_cnt;
    logic [13:0] dedicated_start;
    logic [13:0] shared_start;
  } tx_layout_t;

endpackage : can_filter_pkg

// ---- tb/msg_ram_model.sv ----
// message ram model for the filter walk read port
`timescale 1ns/1ps
module msg_ram_model (
  // clock
  input wire logic clk,
  // read port
  input wire logic rd,
  input wire logic [13:0] addr,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:511];

  // the walk samples the word in the strobe cycle itself, so the read is asynchronous;
  // without a strobe the inverse shows, so a word taken at the wrong edge is caught
  assign rdata = rd ? mem[addr[8:0]] : ~mem[addr[8:0]];
endmodule : msg_ram_model

// ---- tb/tb_top.sv ----
// self-checking bench for the extended filter and tx buffer configuration block
`timescale 1ns/1ps
`include "can_filter_consts.svh"
module tb_top
  import can_filter_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam logic [13:0] LS = 14'h0040; // filter list word address
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic filt_start = 1'b0;
  logic [28:0] rx_ext_id = 29'h0;
  logic [31:0] reg_rdata_ff, ram_rdata, lfsr, rv;
  logic ram_rd_ff, filt_busy_ff, filt_done_ff, hpm_irq_ff;
  logic [13:0] ram_addr_ff, last_a;
  filt_result_t filt_result_ff;
  tx_layout_t tx_layout_ff;
  int num_errors = 0;
  int checks = 0;
  int nrd;

  can_ext_filter_txbuf #(.ELEM_WORDS(4)) can_ext_filter_txbuf_i (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .filt_start(filt_start), .rx_ext_id(rx_ext_id), .ram_rd_ff(ram_rd_ff),
    .ram_addr_ff(ram_addr_ff), .ram_rdata(ram_rdata), .filt_busy_ff(filt_busy_ff),
    .filt_done_ff(filt_done_ff), .filt_result_ff(filt_result_ff),
    .hpm_irq_ff(hpm_irq_ff), .tx_layout_ff(tx_layout_ff));

  msg_ram_model msg_ram_model_i (.clk(clk), .rd(ram_rd_ff), .addr(ram_addr_ff),
    .rdata(ram_rdata));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata_ff;
    chk(64'(rv), 64'(e));
  endtask : rchk

  function automatic logic [31:0] nxt_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_lfsr

  // counts clamp at 32; shared buffers sit after the dedicated ones
  function automatic logic [63:0] exp_lay(input logic [31:0] d);
    logic [5:0] s;
    logic [5:0] n;
    s = (d[29:24] > 6'd32) ? 6'd32 : d[29:24];
    n = (d[21:16] > 6'd32) ? 6'd32 : d[21:16];
    return {23'h0, d[30], s, n, d[15:2], d[15:2] + 14'(n) * 14'd4};
  endfunction : exp_lay

  task automatic txbc(input logic [31:0] d);
    wr(`OFS_TX_BUFFER_CONFIG, d);
    rchk(`OFS_TX_BUFFER_CONFIG, d & 32'h7f3f_fffc);
    chk(64'(tx_layout_ff), exp_lay(d));
  endtask : txbc

  function automatic logic [63:0] exp_res(input logic [2:0] c, input logic [5:0] k,
                                          input logic hit);
    logic acc;
    dest_t d;
    acc = hit && (c inside {3'd1, 3'd2, 3'd5, 3'd6, 3'd7});
    d = !acc ? DEST_NONE : (c == 3'd7) ? DEST_RXBUF : (c[0] ? DEST_FIFO0 : DEST_FIFO1);
    return 64'({acc, d, hit, hit ? k : 6'h0, hit && (c inside {3'd4, 3'd5, 3'd6})});
  endfunction : exp_res

  function automatic logic [63:0] got_res();
    filt_result_t r;
    r = filt_result_ff;
    return 64'({r.accept, r.dest, r.matched, r.matched ? r.index : 6'h0, r.prio});
  endfunction : got_res

  task automatic elem(input int k, input logic [2:0] c, input logic [1:0] t,
                      input logic [28:0] a, input logic [28:0] b);
    msg_ram_model_i.mem[LS + 2 * k] = {c, a};
    msg_ram_model_i.mem[LS + 2 * k + 1] = {t, 1'b0, b};
  endtask : elem

  // one walk, counting message ram reads until the done pulse
  task automatic run(input logic [28:0] id);
    nrd = 0;
    @(posedge clk);
    filt_start <= 1'b1;
    rx_ext_id <= id;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk);
      filt_start <= 1'b0;
      #1;
      if (ram_rd_ff === 1'b1)
      begin
        nrd++;
        last_a = ram_addr_ff;
      end
      if (filt_done_ff === 1'b1)
        break;
    end
    chk(64'(filt_done_ff), 64'h1);
  endtask : run

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    lfsr = 32'd43;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rchk(`OFS_CORE_VERSION, 32'h1000_0101);
    wr(`OFS_CORE_VERSION, 32'hffff_ffff);
    rchk(`OFS_CORE_VERSION, 32'h1000_0101);
    rchk(8'h04, 32'h0);
    rchk(`OFS_CONTROL, 32'h1);
    wr(`OFS_TX_BUFFER_CONFIG, 32'h4020_1004);
    rchk(`OFS_TX_BUFFER_CONFIG, 32'h0);
    chk(64'(tx_layout_ff), 64'h0);
    wr(`OFS_CONTROL, 32'h3);
    txbc(32'h4020_1004);
    txbc(32'h3f3f_ffff);
    txbc(32'h0021_0008);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt_lfsr(lfsr);
      txbc({1'b0, lfsr[30], 2'b00, lfsr[27:24], 4'h0, lfsr[19:16], lfsr[15:0]});
    end
    wr(`OFS_INT_ENABLE, 32'h100);
    wr(`OFS_EXT_FILTER_CFG, {9'h0, 7'd1, LS, 2'b00});
    // every configuration code on the lower range boundary
    for (int c = 0; c < 8; c++)
    begin
      elem(0, 3'(c), 2'd0, 29'd100, 29'h4c8);
      run(29'd100);
      chk(got_res(), exp_res(3'(c), 6'd0, c != 0));
      chk(64'(nrd), 64'd2);
      if (c == 7)
        chk(64'({filt_result_ff.debug_kind, filt_result_ff.rxbuf_idx}), 64'h88);
      repeat (2) @(posedge clk);
      #1;
      chk(64'(hpm_irq_ff), 64'(c >= 4 && c <= 6));
      if (c >= 4 && c <= 6)
      begin
        rchk(`OFS_PRIO_STATUS, 32'h200 | 32'(c & 3));
        wr(`OFS_INT_FLAG, 32'h100);
        rchk(`OFS_INT_FLAG, 32'h0);
        chk(64'(hpm_irq_ff), 64'h0);
      end
    end
    // disabled first element, miss, then hit on the upper boundary
    wr(`OFS_EXT_FILTER_CFG, {9'h0, 7'd3, LS, 2'b00});
    elem(0, 3'd0, 2'd0, 29'd0, 29'd999);
    elem(1, 3'd1, 2'd0, 29'd10, 29'd20);
    elem(2, 3'd2, 2'd0, 29'd30, 29'd40);
    run(29'd40);
    chk(got_res(), exp_res(3'd2, 6'd2, 1'b1));
    chk(64'(nrd), 64'd6);
    chk(64'(last_a), 64'(LS + 14'd5));
    run(29'd41);
    chk(got_res(), exp_res(3'd0, 6'd0, 1'b0));
    chk(64'(nrd), 64'd6);
    wr(`OFS_EXT_FILTER_CFG, {9'h0, 7'd0, LS, 2'b00});
    run(29'd15);
    chk(64'(nrd), 64'd0);
    chk(got_res(), exp_res(3'd0, 6'd0, 1'b0));
    // random ranges; second id never below the first
    wr(`OFS_EXT_FILTER_CFG, {9'h0, 7'd1, LS, 2'b00});
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nxt_lfsr(lfsr);
      elem(0, 3'd1, 2'd0, 29'h100, 29'h100 + 29'(lfsr[7:0]));
      run(29'h100 + 29'(lfsr[15:8]));
      chk(got_res(), exp_res(3'd1, 6'd0, lfsr[15:8] <= lfsr[7:0]));
    end
    // masked exact compare, filter type ignored
    wr(`OFS_EXT_ID_MASK, 32'h1fff_fff0);
    elem(0, 3'd7, 2'd3, 29'h1234_5670, 29'h4c8);
    run(29'h1234_5675);
    chk(got_res(), exp_res(3'd7, 6'd0, 1'b1));
    run(29'h1234_5680);
    chk(got_res(), exp_res(3'd7, 6'd0, 1'b0));
    end_of_test();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule : tb_top
